// [acu_defines.svh]
// Constants for the adapter-control register bank
`ifndef ACU_DEFINES_SVH
`define ACU_DEFINES_SVH
// Bit positions
`define ACU_B_NTYPE0   0
`define ACU_B_NTYPE2   2
`define ACU_B_SWACK    4
`define ACU_B_DDIR     5
`define ACU_B_SWREQ    6
`define ACU_B_PDMAEN   7
`define ACU_B_ADAPTER_RESET_BIT   8
`define ACU_B_CPHALT   9
`define ACU_B_BOOT     10
`define ACU_B_RSV      11
`define ACU_B_SYS_INT_ENABLE   12
`define ACU_B_PEN      13
`define ACU_B_NSPEED   14
`define ACU_B_NTYPE    15
// Reset values of stored bits
`define ACU_RST_SYS_INT_ENABLE 1'h0
`define ACU_RST_PDMAEN 1'h0
`define ACU_RST_SWACK  1'h0
`define ACU_RST_CPHALT 1'h1
`define ACU_RST_ADAPTER_RESET_BIT 1'h1
`define ACU_RST_NSPEED 1'h0
`define ACU_RST_NTYPE  1'h1
`endif

// [acu_pkg.sv]
// Types for the adapter-control register bank
package acu_pkg;
  typedef enum logic [1:0] {
    ACU_NET_RSVD  = 2'h0,
    ACU_NET_TR16  = 2'h1,
    ACU_NET_8023  = 2'h2,
    ACU_NET_TR4   = 2'h3
  } acu_net_t;
endpackage

// [acu_adapter_control.sv]
// Adapter-control register: upper control bits, host interrupt and pseudo-DMA request logic
`include "acu_defines.svh"

module acu_adapter_control
  import acu_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  // Host register port
  input wire logic i_wr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  // Adapter-side signals
  input wire logic i_host_int_flag,
  input wire logic i_hold_req,
  input wire logic i_ddir,
  input wire logic i_clk_fail,
  input wire logic i_chapter_boot,
  input wire logic i_mem_cycle,
  input wire logic i_cas_slot,
  input wire logic [15:0] i_xfer_data,
  input wire logic i_xfer_parity,
  input wire logic i_xfer_valid,
  // Strap pins
  input wire logic i_boot_default_strap,
  input wire logic i_parity_default_strap,
  input wire logic i_net_type_strap0,
  input wire logic i_net_type_strap1,
  input wire logic i_net_type_strap2,
  // Outputs
  output logic o_host_int_request,
  output logic o_column_strobe_out_n,
  output logic o_rom_enable_out_n,
  output logic o_parity_error,
  output logic o_net_speed_select_out,
  output logic o_net_type_select_out,
  output logic o_adapter_reset,
  output logic o_cp_halt,
  output logic o_pdma_active
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [4:0] pin_s1_q, pin_s2_q;
  logic strap_take_q;
  always_ff @(posedge i_mclk) begin
    if (i_ce) begin
      pin_s1_q <= {i_boot_default_strap, i_parity_default_strap, i_net_type_strap2,
                   i_net_type_strap1, i_net_type_strap0};
      pin_s2_q <= pin_s1_q;
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  logic boot_q, boot_d, sys_int_enable_q, sys_int_enable_d, pen_q, pen_d;
  logic pdmaen_q, pdmaen_d, swack_q, swack_d, cphalt_q, cphalt_d;
  logic adapter_reset_bit_q, adapter_reset_bit_d, nspeed_q, nspeed_d, ntype_q, ntype_d;
  logic strap_take_d;

  always_comb begin
    boot_d = boot_q;
    sys_int_enable_d = sys_int_enable_q;
    pen_d = pen_q;
    pdmaen_d = pdmaen_q;
    swack_d = swack_q;
    cphalt_d = cphalt_q;
    adapter_reset_bit_d = adapter_reset_bit_q | i_clk_fail;
    nspeed_d = nspeed_q;
    ntype_d = ntype_q;
    strap_take_d = 1'h0;
    // Straps are caught four cycles after reset, once synchronisers hold them
    if (strap_take_q) begin
      boot_d = pin_s2_q[4];
      pen_d = pin_s2_q[3];
    end
    if (i_wr) begin
      boot_d = i_wdata[`ACU_B_BOOT];
      sys_int_enable_d = i_wdata[`ACU_B_SYS_INT_ENABLE];
      pen_d = i_wdata[`ACU_B_PEN];
      pdmaen_d = i_wdata[`ACU_B_PDMAEN];
      // Ack may only become one in pseudo-DMA mode
      swack_d = i_wdata[`ACU_B_SWACK] & i_wdata[`ACU_B_PDMAEN];
      cphalt_d = i_wdata[`ACU_B_CPHALT];
      // Clock failure sets reset; a write cannot clear it in the same cycle
      adapter_reset_bit_d = i_wdata[`ACU_B_ADAPTER_RESET_BIT] | i_clk_fail;
      if (adapter_reset_bit_q) begin
        nspeed_d = i_wdata[`ACU_B_NSPEED];
        ntype_d = i_wdata[`ACU_B_NTYPE];
      end
    end
  end

  logic [1:0] take_cnt_q;
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      boot_q <= 1'h0;
      pen_q <= 1'h0;
      sys_int_enable_q <= `ACU_RST_SYS_INT_ENABLE;
      pdmaen_q <= `ACU_RST_PDMAEN;
      swack_q <= `ACU_RST_SWACK;
      cphalt_q <= `ACU_RST_CPHALT;
      adapter_reset_bit_q <= `ACU_RST_ADAPTER_RESET_BIT;
      nspeed_q <= `ACU_RST_NSPEED;
      ntype_q <= `ACU_RST_NTYPE;
      take_cnt_q <= 2'h0;
      strap_take_q <= 1'h0;
    end else if (i_ce) begin
      boot_q <= boot_d;
      sys_int_enable_q <= sys_int_enable_d;
      pen_q <= pen_d;
      pdmaen_q <= pdmaen_d;
      swack_q <= swack_d;
      cphalt_q <= cphalt_d;
      adapter_reset_bit_q <= adapter_reset_bit_d;
      nspeed_q <= nspeed_d;
      ntype_q <= ntype_d;
      if (take_cnt_q != 2'h3) begin
        take_cnt_q <= take_cnt_q + 2'h1;
      end
      strap_take_q <= (take_cnt_q == 2'h2);
    end
  end

  // ----------------------------------------
  // Pseudo-DMA and host interrupt
  // ----------------------------------------
  logic pdma_req, pdma_act, int_d, int_q;
  always_comb begin
    pdma_req = pdmaen_q & i_hold_req & ~swack_q;
    pdma_act = pdmaen_q & i_hold_req & swack_q;
    int_d = pdma_req | (sys_int_enable_q & i_host_int_flag);
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      int_q <= 1'h0;
    end else if (i_ce) begin
      int_q <= int_d;
    end
  end

  // ----------------------------------------
  // Memory strobes and parity
  // ----------------------------------------
  // RAM boot needs CAS in boot chapters, ROM boot uses ROM enable instead
  logic cas_d, rom_d, perr_d, cas_q, rom_q, perr_q;
  always_comb begin
    cas_d = ~(i_mem_cycle & i_cas_slot & (boot_q | ~i_chapter_boot));
    rom_d = ~(i_mem_cycle & i_chapter_boot & ~boot_q);
    perr_d = pen_q & i_xfer_valid & ~(^{i_xfer_data, i_xfer_parity});
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cas_q <= 1'h1;
      rom_q <= 1'h1;
      perr_q <= 1'h0;
    end else if (i_ce) begin
      cas_q <= cas_d | adapter_reset_bit_q;
      rom_q <= rom_d | adapter_reset_bit_q;
      perr_q <= perr_d & ~adapter_reset_bit_q;
    end
  end

  // ----------------------------------------
  // Outputs and readback
  // ----------------------------------------
  always_comb begin
    o_rdata = 16'h0;
    o_rdata[`ACU_B_NTYPE2:`ACU_B_NTYPE0] = pin_s2_q[2:0];
    o_rdata[`ACU_B_SWACK] = swack_q;
    o_rdata[`ACU_B_DDIR] = i_ddir;
    o_rdata[`ACU_B_SWREQ] = i_hold_req;
    o_rdata[`ACU_B_PDMAEN] = pdmaen_q;
    o_rdata[`ACU_B_ADAPTER_RESET_BIT] = adapter_reset_bit_q;
    o_rdata[`ACU_B_CPHALT] = cphalt_q;
    o_rdata[`ACU_B_BOOT] = boot_q;
    o_rdata[`ACU_B_SYS_INT_ENABLE] = sys_int_enable_q;
    o_rdata[`ACU_B_PEN] = pen_q;
    o_rdata[`ACU_B_NSPEED] = nspeed_q;
    o_rdata[`ACU_B_NTYPE] = ntype_q;
  end

  assign o_host_int_request = int_q;
  assign o_column_strobe_out_n = cas_q;
  assign o_rom_enable_out_n = rom_q;
  assign o_parity_error = perr_q;
  assign o_net_speed_select_out = nspeed_q;
  assign o_net_type_select_out = ntype_q;
  assign o_adapter_reset = adapter_reset_bit_q;
  assign o_cp_halt = cphalt_q;
  assign o_pdma_active = pdma_act;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence req_seq;
    pdmaen_q && i_hold_req && !swack_q;
  endsequence

  pdma_int_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce and req_seq) |=> o_host_int_request)
    else $error("pseudo-DMA request missed interrupt");
  pdma_act_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && pdmaen_q && i_hold_req && swack_q && !(sys_int_enable_q && i_host_int_flag)) |=> !o_host_int_request)
    else $error("interrupt during active pseudo-DMA");
  sys_int_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && sys_int_enable_q && i_host_int_flag) |=> o_host_int_request)
    else $error("system interrupt missed");
  int_gate_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && !pdmaen_q && !(sys_int_enable_q && i_host_int_flag)) |=> !o_host_int_request)
    else $error("spurious host interrupt");
  nsel_lock_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (!adapter_reset_bit_q) |=> $stable(o_net_speed_select_out) && $stable(o_net_type_select_out))
    else $error("network select changed outside reset");
  nsel_init_a: assert property (@(posedge i_mclk)
    $fell(i_srst) |-> (o_net_type_select_out && !o_net_speed_select_out))
    else $error("network select reset value wrong");
  rom_boot_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (i_ce && !adapter_reset_bit_q && boot_q && i_mem_cycle) |=> o_rom_enable_out_n)
    else $error("ROM enable with RAM boot");
  par_off_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    (!pen_q) |=> !o_parity_error)
    else $error("parity error while checking off");
  ack_mode_a: assert property (@(posedge i_mclk) disable iff (i_srst)
    !pdmaen_q |-> !swack_q)
    else $error("ack set outside pseudo-DMA");

endmodule

// [acu_host_model.sv]
// Host processor model: register writes and board straps
module acu_host_model (
  // Clock
  input wire logic i_mclk,
  // Register write port
  output logic o_wr,
  output logic [15:0] o_wdata,
  // Board straps
  output logic o_boot_strap,
  output logic o_par_strap,
  output logic [2:0] o_net_straps
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------
  // Straps and writes
  // ------------------
  // Straps never move while running
  assign o_boot_strap = 1'h1;
  assign o_par_strap = 1'h0;
  assign o_net_straps = 3'h5;
  initial begin
    o_wr = 1'h0;
    o_wdata = 16'h0;
  end
  // Data scrambled after release so stale words are never mistaken for valid
  task automatic wr(input logic [15:0] d);
    @(negedge i_mclk);
    o_wr = 1'h1;
    o_wdata = d & 16'hf7ff;
    @(negedge i_mclk);
    o_wr = 1'h0;
    o_wdata = ~o_wdata;
  endtask
endmodule

// [adapter_control_upper_bits_tb.sv]
// Self-checking bench for the adapter-control register bank
module adapter_control_upper_bits_tb;
  import acu_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {string nm; logic [19:0] e; logic [19:0] m;} acu_note_t;
  logic mclk, srst, wr, hreq, flag, ddir, xval, xpar, bstr, pstr;
  logic cb, mc, cs;
  logic [15:0] wd, rd, xdat;
  logic [2:0] nstr;
  logic hint, cas_n, rom_n, perr, spd, typ, ares, halt, pact;
  logic [19:0] obs;
  int mismatches, n_tests;
  acu_note_t q[$];
  event ev;
  assign obs = {hint, perr, typ, spd, rd};
  acu_host_model i_acu_host_model (.i_mclk(mclk), .o_wr(wr), .o_wdata(wd),
    .o_boot_strap(bstr), .o_par_strap(pstr), .o_net_straps(nstr));
  acu_adapter_control i_acu_adapter_control (.i_mclk(mclk), .i_srst(srst), .i_ce(1'h1),
    .i_wr(wr), .i_wdata(wd), .o_rdata(rd), .i_host_int_flag(flag), .i_hold_req(hreq),
    .i_ddir(ddir), .i_clk_fail(1'h0), .i_chapter_boot(cb), .i_mem_cycle(mc),
    .i_cas_slot(cs), .i_xfer_data(xdat), .i_xfer_parity(xpar), .i_xfer_valid(xval),
    .i_boot_default_strap(bstr), .i_parity_default_strap(pstr),
    .i_net_type_strap0(nstr[0]), .i_net_type_strap1(nstr[1]), .i_net_type_strap2(nstr[2]),
    .o_host_int_request(hint), .o_column_strobe_out_n(cas_n), .o_rom_enable_out_n(rom_n),
    .o_parity_error(perr), .o_net_speed_select_out(spd), .o_net_type_select_out(typ),
    .o_adapter_reset(ares), .o_cp_halt(halt), .o_pdma_active(pact));
  // ------------------
  // Checking helpers
  // ------------------
  task automatic chk(input string nm, input logic [19:0] s, input logic [19:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic note(input string nm, input logic [19:0] e, input logic [19:0] m);
    q.push_back('{nm, e, m});
    -> ev;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    acu_note_t n;
    forever begin
      @(ev);
      while (q.size() > 0) begin
        n = q.pop_front();
        chk(n.nm, obs & n.m, n.e & n.m);
      end
    end
  end
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    test_done();
  end
  // ------------------
  // Scenarios
  // ------------------
  initial begin
    logic [15:0] d;
    logic [4:0] r;
    logic [1:0] c;
    logic e;
    srst = 1'h1;
    {hreq, flag, ddir, xval, xpar} = 5'h0;
    {cb, mc, cs} = 3'h0;
    xdat = 16'h0;
    void'($urandom(32'h8c03fbe1));
    repeat (6) @(negedge mclk);
    srst = 1'h0;
    repeat (4) @(negedge mclk);
    note("reset", {4'h2, 16'h8705}, 20'hfffff);
    $display("test reset done");
    // Select codes taken while adapter reset is held
    for (int s = 0; s < 4; s++) begin
      c = acu_net_t'(s);
      i_acu_host_model.wr({c[0], c[1], 14'h0300});
      note("net_select", {2'h0, c[0], c[1], c[0], c[1], 14'h0305}, 20'hfffff);
    end
    i_acu_host_model.wr(16'hc000);
    i_acu_host_model.wr(16'h4000);
    note("net_hold", {4'h3, 16'h0}, 20'h30000);
    $display("test net select done");
    // Random pseudo-DMA and interrupt combinations
    for (int i = 0; i < 32; i++) begin
      r = 5'($urandom());
      d = {3'h0, r[0], 4'h2, r[1], 2'h0, r[2], 4'h0};
      i_acu_host_model.wr(d);
      hreq = r[3];
      flag = r[4];
      ddir = r[0] ^ r[3];
      repeat (2) @(negedge mclk);
      e = (r[1] & r[3] & ~r[2]) | (r[0] & r[4]);
      // Select bits were left at 11 by the hold test and stay there
      note("host_int", {e, 3'h3, 2'h3, d[13:7], hreq, ddir, d[4] & d[7], 4'h5}, 20'hfffff);
    end
    $display("test interrupt done");
    // Bad then good transfer, checking on and off
    for (int p = 1; p >= 0; p--) begin
      i_acu_host_model.wr({2'h0, p[0], 13'h0200});
      xdat = 16'($urandom());
      xpar = ^xdat;
      xval = 1'h1;
      @(negedge mclk);
      xval = 1'h0;
      note("parity_bad", {1'h0, p[0], 18'h0}, 20'h40000);
      xpar = ~^xdat;
      xval = 1'h1;
      @(negedge mclk);
      xval = 1'h0;
      note("parity_good", 20'h0, 20'h40000);
    end
    $display("test parity done");
    // Boot chapter access with ROM boot, then RAM boot
    {cb, mc, cs} = 3'h7;
    repeat (2) @(negedge mclk);
    chk("strobes_rom", {cas_n, rom_n}, 2'h2);
    i_acu_host_model.wr(16'h0600);
    repeat (2) @(negedge mclk);
    chk("strobes_ram", {cas_n, rom_n}, 2'h1);
    {cb, mc, cs} = 3'h0;
    $display("test strobes done");
    @(negedge mclk);
    test_done();
  end
endmodule
